// ---- bench/dnos_host_model.sv ----
// host model that drains and logs the message stream
`include "dnos_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module dnos_host_model import dnos_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic msgValid,
  input wire dnos_msg_t msgData,
  output logic msgReady
);
  dnos_msg_t got[$];
  int secSeen;

  // slow mode stalls every other cycle so the fifo has to hold messages
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msgReady <= 1'b0;
    end else begin
      if (msgValid && msgReady) begin
        got.push_back(msgData);
        if (msgData.msgClass === `DNOS_CLASS_SEC) secSeen++;
      end
      msgReady <= slow ? ~msgReady : 1'b1;
    end
  end
endmodule : dnos_host_model

`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking testbench for the navigation output sequencer
`include "dnos_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_top import dnos_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic epochTick = 1'b0;
  dnos_sol_t fusedSol = '0;
  dnos_sol_t gnssSol = '0;
  logic cfgWrite = 1'b0;
  logic [2:0] cfgItem = 3'h0;
  logic [7:0] cfgValue = 8'h00;
  logic slow = 1'b0;
  logic msgReady, msgValid, secondaryRun, priIntegrityUse;
  logic secIntegrityUse, epochOverrun, sequencerBusy, ovSeen;
  dnos_msg_t msgData;
  dnos_msg_t exq[$];
  int errCount = 0;
  int checks = 0;

  always #50 clk = ~clk;

  dnos_sequencer dut (.clk(clk), .reset_n(reset_n), .epochTick(epochTick),
    .fusedSol(fusedSol), .gnssSol(gnssSol), .cfgWrite(cfgWrite),
    .cfgItem(cfgItem), .cfgValue(cfgValue), .msgReady(msgReady),
    .msgValid(msgValid), .msgData(msgData), .secondaryRun(secondaryRun),
    .priIntegrityUse(priIntegrityUse), .secIntegrityUse(secIntegrityUse),
    .epochOverrun(epochOverrun), .sequencerBusy(sequencerBusy));

  dnos_host_model host (.clk(clk), .reset_n(reset_n), .slow(slow),
    .msgValid(msgValid), .msgData(msgData), .msgReady(msgReady));

  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cfg(input logic [2:0] item, input logic [7:0] val);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgItem = item;
    cfgValue = val;
    @(negedge clk);
    cfgWrite = 1'b0;
    @(negedge clk);
    @(negedge clk);
  endtask : cfg

  task automatic push(input logic [7:0] cls, input logic [7:0] id,
                      input logic [31:0] pl);
    exq.push_back({cls, id, pl});
  endtask : push

  // one epoch; dbl sends a second tick while the sequence is busy
  task automatic epoch(input logic [7:0] n, input bit dbl, input bit pp,
                       input bit pt, input bit sp, input bit st, input bit se);
    logic [31:0] fp, ft, gp, gt;
    logic done;
    fp = {24'ha00000, n};
    ft = {24'hb00000, n};
    gp = {24'hc00000, n};
    gt = {24'hd00000, n};
    exq.delete();
    host.got.delete();
    ovSeen = 1'b0;
    @(negedge clk);
    fusedSol = {fp, ft};
    gnssSol = {gp, gt};
    epochTick = 1'b1;
    @(negedge clk);
    epochTick = 1'b0;
    fusedSol = '1;
    gnssSol = '1;
    if (dbl) begin
      @(negedge clk);
      epochTick = 1'b1;
      @(negedge clk);
      epochTick = 1'b0;
      // the overrun pulse stands only until the next rising edge
      ovSeen |= (epochOverrun === 1'b1);
    end
    done = 1'b0;
    for (int i = 0; i < 200 && !done; i++) begin
      @(negedge clk);
      ovSeen |= (epochOverrun === 1'b1);
      done = (sequencerBusy === 1'b0 && msgValid === 1'b0);
    end
    chk("drainDone", 48'h1, {47'h0, done});
    chk("epochOverrun", {47'h0, dbl}, {47'h0, ovSeen});
    if (pp) push(`DNOS_CLASS_PRI, `DNOS_ID_PVT, fp);
    if (pt) push(`DNOS_CLASS_PRI, `DNOS_ID_TIME, ft);
    push(`DNOS_CLASS_PRI, `DNOS_ID_EOE, ft);
    if (sp) push(`DNOS_CLASS_SEC, `DNOS_ID_PVT, gp);
    if (st) push(`DNOS_CLASS_SEC, `DNOS_ID_TIME, gt);
    if (se) push(`DNOS_CLASS_SEC, `DNOS_ID_EOE, gt);
    chk("msgCount", 48'(exq.size()), 48'(host.got.size()));
    for (int i = 0; i < exq.size() && i < host.got.size(); i++) begin
      chk("msgData", exq[i], host.got[i]);
    end
  endtask : epoch

  task automatic conclude();
    if (errCount == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #(4000 * 100);
    errCount++;
    conclude();
  end

  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("secondaryRun", 48'h0, {47'h0, secondaryRun});
    chk("priIntegrityUse", 48'h1, {47'h0, priIntegrityUse});
    chk("secIntegrityUse", 48'h1, {47'h0, secIntegrityUse});
    // dropped tick must not add a second set of messages
    epoch(8'h01, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    cfg(`DNOS_ITEM_SEC_ENABLE, 8'h01);
    chk("secondaryRun", 48'h1, {47'h0, secondaryRun});
    epoch(8'h02, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    cfg(`DNOS_ITEM_SEC_PVT_RATE, 8'h01);
    cfg(`DNOS_ITEM_SEC_TIME_RATE, 8'h03);
    slow = 1'b1;
    epoch(8'h03, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    epoch(8'h04, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    cfg(`DNOS_ITEM_PRI_PVT_RATE, 8'h02);
    cfg(`DNOS_ITEM_TEXT_MODE, 8'h01);
    epoch(8'h05, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    slow = 1'b0;
    epoch(8'h06, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    // a zero primary rate silences that message only
    cfg(`DNOS_ITEM_PRI_TIME_RATE, 8'h00);
    epoch(8'h07, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    cfg(`DNOS_ITEM_SEC_INTEG, 8'h00);
    chk("secIntegrityUse", 48'h0, {47'h0, secIntegrityUse});
    chk("priIntegrityUse", 48'h1, {47'h0, priIntegrityUse});
    cfg(`DNOS_ITEM_PRI_INTEG, 8'h00);
    chk("priIntegrityUse", 48'h0, {47'h0, priIntegrityUse});
    chk("secondaryCount", 48'd10, 48'(host.secSeen));
    conclude();
  end
endmodule : tb_top

`default_nettype wire

// ---- hw/dnos_cfg.svh ----
// constants for the dual navigation output sequencer
`ifndef DNOS_CFG_SVH
`define DNOS_CFG_SVH

`define DNOS_RATE_W 8
`define DNOS_FIFO_DEPTH 8
// message class and id codes are arbitrary values
`define DNOS_CLASS_PRI 8'h10
`define DNOS_CLASS_SEC 8'h11
`define DNOS_ID_PVT 8'h01
`define DNOS_ID_TIME 8'h02
`define DNOS_ID_EOE 8'h03
// kind of message inside one set, and number of slots per set
`define DNOS_KIND_PVT 2'h0
`define DNOS_KIND_TIME 2'h1
`define DNOS_KIND_EOE 2'h2
`define DNOS_SET_SLOTS 3'h3
// configuration item codes on the write port
`define DNOS_ITEM_SEC_ENABLE 3'h0
`define DNOS_ITEM_PRI_INTEG 3'h1
`define DNOS_ITEM_SEC_INTEG 3'h2
`define DNOS_ITEM_PRI_PVT_RATE 3'h3
`define DNOS_ITEM_PRI_TIME_RATE 3'h4
`define DNOS_ITEM_SEC_PVT_RATE 3'h5
`define DNOS_ITEM_SEC_TIME_RATE 3'h6
`define DNOS_ITEM_TEXT_MODE 3'h7
// reset values
`define DNOS_RST_SEC_ENABLE 1'b0
`define DNOS_RST_INTEG 1'b1
`define DNOS_RST_TEXT_MODE 1'b0
`define DNOS_RST_PRI_RATE 8'h01
`define DNOS_RST_SEC_RATE 8'h00

`endif

// ---- hw/dnos_fifo.sv ----
// message fifo with registered full and empty flags
`timescale 1ns/100ps
`default_nettype none

// depth must be a power of two, pointers wrap naturally
module dnos_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW:0] next_count;

  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;

  assign next_count = count + (AW+1)'(doWrite) - (AW+1)'(doRead);
  assign outData = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      wrPtr <= wrPtr + AW'(doWrite);
      rdPtr <= rdPtr + AW'(doRead);
      count <= next_count;
      inReady <= next_count != (AW+1)'(DEPTH);
      outValid <= next_count != '0;
    end
  end

endmodule : dnos_fifo

`default_nettype wire

// ---- hw/dnos_pkg.sv ----
// types shared by the dual navigation output sequencer
`default_nettype none

package dnos_pkg;

  typedef struct packed {
    logic [7:0] msgClass;
    logic [7:0] msgId;
    logic [31:0] payload;
  } dnos_msg_t;

  typedef struct packed {
    logic [31:0] pvtWord;
    logic [31:0] timeWord;
  } dnos_sol_t;

  typedef enum logic {ST_IDLE, ST_SEND} dnos_state_t;

endpackage : dnos_pkg

`default_nettype wire

// ---- hw/dnos_sequencer.sv ----
// per-epoch ordering of primary and secondary navigation messages
// Contract
// - secondary solution stays off from reset until the host enables it
// - secondary rates reset to zero; a zero-rate message is never sent
// - both solutions share one epoch tick, no separate secondary rate
// - per epoch, primary set first, then secondary set, same epoch data
// - each set closes with its own end-of-epoch marker, outside text mode
// - in text mode the secondary set gets no end marker
// - secondary payload layout equals its primary counterpart's
// - secondary configuration writes never touch primary settings
// - secondary integrity use resets to the same default as primary; secondary rates reset to zero, primary rates to one
// - secondary message rates are set apart from primary rates
// - primary reports fused solution, secondary the satellite-only one
`include "dnos_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module dnos_sequencer import dnos_pkg::*; #(
  parameter int RATE_W = `DNOS_RATE_W,
  parameter int FIFO_DEPTH = `DNOS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic epochTick,
  input wire dnos_sol_t fusedSol,
  input wire dnos_sol_t gnssSol,
  input wire logic cfgWrite,
  input wire logic [2:0] cfgItem,
  input wire logic [RATE_W-1:0] cfgValue,
  input wire logic msgReady,
  output logic msgValid,
  output dnos_msg_t msgData,
  output logic secondaryRun,
  output logic priIntegrityUse,
  output logic secIntegrityUse,
  output logic epochOverrun,
  output logic sequencerBusy
);

  // rate slots: 0 primary pvt, 1 primary time, 2 sec pvt, 3 sec time
  logic [RATE_W-1:0] rate [4];
  logic [RATE_W-1:0] cnt [4];
  logic secEnable;
  logic textMode;
  dnos_state_t state;
  logic [5:0] pend;
  dnos_sol_t priLatch;
  dnos_sol_t secLatch;
  logic secSeen;

  function automatic logic isDue(input logic [RATE_W-1:0] r,
                                 input logic [RATE_W-1:0] c);
    return (r != '0) && (c == '0);
  endfunction : isDue

  function automatic logic [RATE_W-1:0] stepCount(
      input logic [RATE_W-1:0] r, input logic [RATE_W-1:0] c);
    logic [RATE_W:0] up;
    up = {1'b0, c} + (RATE_W+1)'(1);
    if (r == '0 || up >= {1'b0, r}) begin
      return '0;
    end
    return up[RATE_W-1:0];
  endfunction : stepCount

  function automatic logic [2:0] lowestSet(input logic [5:0] p);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (p[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowestSet

  // configuration decode
  wire wrSecEnable = cfgWrite && cfgItem == `DNOS_ITEM_SEC_ENABLE;
  wire wrPriInteg = cfgWrite && cfgItem == `DNOS_ITEM_PRI_INTEG;
  wire wrSecInteg = cfgWrite && cfgItem == `DNOS_ITEM_SEC_INTEG;
  wire wrTextMode = cfgWrite && cfgItem == `DNOS_ITEM_TEXT_MODE;
  wire wrRate = cfgWrite && cfgItem >= `DNOS_ITEM_PRI_PVT_RATE
                && cfgItem <= `DNOS_ITEM_SEC_TIME_RATE;
  wire [1:0] rateSlot = 2'(cfgItem - `DNOS_ITEM_PRI_PVT_RATE);

  // epoch acceptance; a tick during a running sequence is dropped
  wire epochAccept = epochTick && state == ST_IDLE;
  wire [3:0] due;
  assign due[0] = isDue(rate[0], cnt[0]);
  assign due[1] = isDue(rate[1], cnt[1]);
  assign due[2] = isDue(rate[2], cnt[2]) && secEnable;
  assign due[3] = isDue(rate[3], cnt[3]) && secEnable;
  wire secEoe = secEnable && !textMode;
  wire [5:0] newPend = {secEoe, due[3], due[2], 1'b1, due[1], due[0]};

  // message build: one builder for both sets, only class and source solution differ
  wire [2:0] selIdx = lowestSet(pend);
  wire isSecSlot = selIdx >= `DNOS_SET_SLOTS;
  wire [1:0] kind = isSecSlot ? 2'(selIdx - `DNOS_SET_SLOTS) : selIdx[1:0];
  wire dnos_sol_t srcSol = isSecSlot ? secLatch : priLatch;
  wire [7:0] selClass = isSecSlot ? `DNOS_CLASS_SEC : `DNOS_CLASS_PRI;
  wire [7:0] selId = kind == `DNOS_KIND_PVT ? `DNOS_ID_PVT :
                     kind == `DNOS_KIND_TIME ? `DNOS_ID_TIME : `DNOS_ID_EOE;
  // end markers carry the epoch time word
  wire [31:0] selPayload = kind == `DNOS_KIND_PVT ? srcSol.pvtWord
                                                  : srcSol.timeWord;
  wire dnos_msg_t pushMsg = '{msgClass: selClass, msgId: selId,
                              payload: selPayload};
  wire pushValid = state == ST_SEND && pend != '0;
  wire fifoInReady;
  wire push = pushValid && fifoInReady;
  wire [5:0] next_pend = pend & ~(6'h01 << selIdx);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      secEnable <= `DNOS_RST_SEC_ENABLE;
      textMode <= `DNOS_RST_TEXT_MODE;
      priIntegrityUse <= `DNOS_RST_INTEG;
      secIntegrityUse <= `DNOS_RST_INTEG;
      secondaryRun <= 1'b0;
    end else begin
      if (wrSecEnable) secEnable <= cfgValue[0];
      if (wrTextMode) textMode <= cfgValue[0];
      if (wrPriInteg) priIntegrityUse <= cfgValue[0];
      if (wrSecInteg) secIntegrityUse <= cfgValue[0];
      secondaryRun <= secEnable;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rate[0] <= `DNOS_RST_PRI_RATE;
      rate[1] <= `DNOS_RST_PRI_RATE;
      rate[2] <= `DNOS_RST_SEC_RATE;
      rate[3] <= `DNOS_RST_SEC_RATE;
      cnt <= '{default: '0};
    end else begin
      if (wrRate) rate[rateSlot] <= cfgValue;
      if (epochAccept) begin
        for (int i = 0; i < 4; i++) begin
          cnt[i] <= stepCount(rate[i], cnt[i]);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      pend <= '0;
      priLatch <= '0;
      secLatch <= '0;
      epochOverrun <= 1'b0;
      sequencerBusy <= 1'b0;
      secSeen <= 1'b0;
    end else begin
      epochOverrun <= epochTick && state != ST_IDLE;
      case (state)
        ST_IDLE: begin
          if (epochAccept) begin
            priLatch <= fusedSol;
            secLatch <= gnssSol;
            pend <= newPend;
            secSeen <= 1'b0;
            state <= ST_SEND;
            sequencerBusy <= 1'b1;
          end
        end
        ST_SEND: begin
          // a full fifo stalls here, so back-pressure never drops a message
          if (push) begin
            pend <= next_pend;
            if (isSecSlot) secSeen <= 1'b1;
            if (next_pend == '0) begin
              state <= ST_IDLE;
              sequencerBusy <= 1'b0;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          pend <= '0;
          sequencerBusy <= 1'b0;
        end
      endcase
    end
  end

  dnos_fifo #(
    .WIDTH($bits(dnos_msg_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(pushValid),
    .inData(pushMsg),
    .inReady(fifoInReady),
    .outValid(msgValid),
    .outData(msgData),
    .outReady(msgReady)
  );

  chk_sec_run_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !secEnable |=> !secondaryRun)
    else $error("secondary solution running while disabled");

  chk_zero_rate_silent: assert property (@(posedge clk)
    disable iff (!reset_n)
    push && isSecSlot && kind != `DNOS_KIND_EOE
    |-> rate[2 + 32'(kind)] != '0)
    else $error("zero-rate secondary message sent");

  chk_epoch_start: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(sequencerBusy) |-> $past(epochTick))
    else $error("sequence started without epoch tick");

  chk_primary_first: assert property (@(posedge clk)
    disable iff (!reset_n)
    push && !isSecSlot |-> !secSeen)
    else $error("primary message after secondary set");

  chk_primary_end: assert property (@(posedge clk) disable iff (!reset_n)
    push && !isSecSlot && kind == `DNOS_KIND_EOE |-> pend[1:0] == 2'b00)
    else $error("primary end marker not last of its set");

  chk_text_no_eoe: assert property (@(posedge clk) disable iff (!reset_n)
    push && isSecSlot && kind == `DNOS_KIND_EOE |-> !textMode)
    else $error("secondary end marker in text mode");

  chk_payload_source: assert property (@(posedge clk)
    disable iff (!reset_n)
    push && isSecSlot && kind == `DNOS_KIND_PVT
    |-> pushMsg.payload == secLatch.pvtWord
        && pushMsg.msgClass == `DNOS_CLASS_SEC)
    else $error("secondary payload not from satellite-only solution");

  chk_cfg_isolation: assert property (@(posedge clk)
    disable iff (!reset_n)
    wrSecInteg || wrSecEnable
    |=> $stable(priIntegrityUse) && $stable(rate[0]) && $stable(rate[1]))
    else $error("secondary write changed primary setting");

  chk_rate_period: assert property (@(posedge clk) disable iff (!reset_n)
    epochAccept && rate[0] != '0 && !wrRate |=> cnt[0] < rate[0])
    else $error("epoch counter outside its rate");

endmodule : dnos_sequencer

`default_nettype wire
